// file: rkpp_pkg.sv
// constants shared by the kernel program partition block
`default_nettype none

package rkpp_pkg;

  localparam int RKPP_ADDR_W = 8;
  localparam int RKPP_DATA_W = 32;
  localparam int RKPP_RAM_W = 16;

  // register byte offsets
  localparam logic [RKPP_ADDR_W-1:0] RKPP_OFS_KBASE = 8'h00;
  localparam logic [RKPP_ADDR_W-1:0] RKPP_OFS_DSIZE = 8'h04;
  localparam logic [RKPP_ADDR_W-1:0] RKPP_OFS_STAT = 8'h08;

  // kernel program base field layout
  localparam int RKPP_KBASE_LSB = 10;
  localparam int RKPP_KBASE_MSB = 15;
  localparam int RKPP_KBASE_FW = RKPP_KBASE_MSB - RKPP_KBASE_LSB + 1;
  localparam int RKPP_IMPL_MSB = 15;
  localparam int RKPP_UPPER_LSB = 16;

  // status bit positions
  localparam int RKPP_STAT_PRESENT = 0;
  localparam int RKPP_STAT_OVER = 1;

  // reset values
  localparam logic [RKPP_KBASE_FW-1:0] RKPP_KBASE_RST = 6'h00;
  localparam logic [RKPP_RAM_W-1:0] RKPP_DSIZE_RST = 16'h0000;
  localparam logic [RKPP_DATA_W-1:0] RKPP_RD_IDLE = 32'h0000_0000;

endpackage : rkpp_pkg

`default_nettype wire

// file: rkpp_region_map.sv
// registered classifier of a data RAM offset into kernel data or program
`timescale 1ns/10ps
`default_nettype none

module rkpp_region_map (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [rkpp_pkg::RKPP_RAM_W-1:0] addr_i,
  input wire logic [rkpp_pkg::RKPP_RAM_W-1:0] base_i,
  input wire logic [rkpp_pkg::RKPP_RAM_W-1:0] size_i,
  output logic in_kprog_o,
  output logic in_kdata_o
);
  import rkpp_pkg::*;

  logic region_on;
  logic above_base;
  logic below_size;
  logic next_prog;
  logic next_data;

  // zero base means no program region at all
  assign region_on = (base_i != '0);
  assign above_base = (addr_i >= base_i);
  assign below_size = (addr_i < size_i);
  assign next_prog = region_on && above_base && below_size;
  assign next_data = below_size && !next_prog;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_kprog_o <= 1'b0;
      in_kdata_o <= 1'b0;
    end else begin
      in_kprog_o <= next_prog;
      in_kdata_o <= next_data;
    end
  end

endmodule : rkpp_region_map

`default_nettype wire

// file: rkpp_partition.sv
// kernel data / kernel program split of on-chip data RAM
//
// Overview of operation
// - base register bits 31-16 hold nothing and always read as zero
// - six writable bits 15-10 set kernel program start when non-zero
// - bits 9-0 are read-only zero, so boundary moves in 1 KB steps
// - any reset clears the base, giving all RAM to kernel data
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module rkpp_partition (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [rkpp_pkg::RKPP_ADDR_W-1:0] ADDR_I,
  input wire logic [rkpp_pkg::RKPP_DATA_W-1:0] WR_DATA_I,
  input wire logic WR_STB_I,
  input wire logic RD_STB_I,
  output logic [rkpp_pkg::RKPP_DATA_W-1:0] RD_DATA_O,
  input wire logic [rkpp_pkg::RKPP_RAM_W-1:0] RAM_ADDR_I,
  output logic [rkpp_pkg::RKPP_RAM_W-1:0] KPROG_BASE_O,
  output logic [rkpp_pkg::RKPP_RAM_W-1:0] KDATA_LEN_O,
  output logic KPROG_PRESENT_O,
  output logic LIMIT_ERR_O,
  output logic IN_KPROG_O,
  output logic IN_KDATA_O
);
  import rkpp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [RKPP_KBASE_FW-1:0] kbase_field;
  logic [RKPP_RAM_W-1:0] kernel_program_ram_base;
  logic [RKPP_RAM_W-1:0] data_ram_size_value;
  logic [RKPP_DATA_W-1:0] rd_data;
  logic [RKPP_RAM_W-1:0] kdata_len;
  logic present;
  logic limit_err;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  logic sel_kbase;
  logic sel_dsize;
  logic sel_stat;
  logic wr_kbase;
  logic wr_dsize;
  logic [RKPP_KBASE_FW-1:0] next_kbase_field;
  logic [RKPP_RAM_W-1:0] next_base;
  logic [RKPP_RAM_W-1:0] next_dsize;
  logic next_present;
  logic next_over;
  logic [RKPP_RAM_W-1:0] next_kdata_len;
  logic [RKPP_DATA_W-1:0] kbase_word;
  logic [RKPP_DATA_W-1:0] dsize_word;
  logic [RKPP_DATA_W-1:0] stat_word;
  logic [RKPP_DATA_W-1:0] next_rd_data;

  assign sel_kbase = (ADDR_I == RKPP_OFS_KBASE);
  assign sel_dsize = (ADDR_I == RKPP_OFS_DSIZE);
  assign sel_stat = (ADDR_I == RKPP_OFS_STAT);
  assign wr_kbase = WR_STB_I && sel_kbase;
  assign wr_dsize = WR_STB_I && sel_dsize;

  // only the six field bits are taken from the bus
  assign next_kbase_field = wr_kbase ? WR_DATA_I[RKPP_KBASE_MSB:RKPP_KBASE_LSB] : kbase_field;
  // low ten bits are wired to zero, so the base register only ever stores zeros there
  assign next_base = {next_kbase_field, {RKPP_KBASE_LSB{1'b0}}};
  assign next_dsize = wr_dsize ? WR_DATA_I[RKPP_IMPL_MSB:0] : data_ram_size_value;

  // zero base leaves the whole RAM to kernel data
  assign next_present = (next_kbase_field != '0);
  // the ordering is software's duty; hardware only reports a breach
  assign next_over = (next_base > next_dsize);
  assign next_kdata_len = next_present ? next_base : next_dsize;

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // upper half of every word is padded with zeros
  assign kbase_word = {{(RKPP_DATA_W-RKPP_UPPER_LSB){1'b0}}, kernel_program_ram_base};
  assign dsize_word = {{(RKPP_DATA_W-RKPP_UPPER_LSB){1'b0}}, data_ram_size_value};
  assign stat_word = {{(RKPP_DATA_W-2){1'b0}}, limit_err, present};
  assign next_rd_data = !RD_STB_I ? RKPP_RD_IDLE :
                        sel_kbase ? kbase_word :
                        sel_dsize ? dsize_word :
                        sel_stat ? stat_word : RKPP_RD_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // flip-flops

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      kbase_field <= RKPP_KBASE_RST;
      kernel_program_ram_base <= {RKPP_KBASE_RST, {RKPP_KBASE_LSB{1'b0}}};
      data_ram_size_value <= RKPP_DSIZE_RST;
    end else begin
      kbase_field <= next_kbase_field;
      kernel_program_ram_base <= next_base;
      data_ram_size_value <= next_dsize;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      present <= 1'b0;
      limit_err <= 1'b0;
      kdata_len <= RKPP_DSIZE_RST;
    end else begin
      present <= next_present;
      limit_err <= next_over;
      kdata_len <= next_kdata_len;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rd_data <= RKPP_RD_IDLE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign RD_DATA_O = rd_data;
  assign KPROG_BASE_O = kernel_program_ram_base;
  assign KDATA_LEN_O = kdata_len;
  assign KPROG_PRESENT_O = present;
  assign LIMIT_ERR_O = limit_err;

  //////////////////////////////////////////////////////////////////////////////
  // address classifier

  // ram address comes from the same clock domain, no synchroniser needed
  rkpp_region_map u_map (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .addr_i(RAM_ADDR_I),
    .base_i(kernel_program_ram_base),
    .size_i(data_ram_size_value),
    .in_kprog_o(IN_KPROG_O),
    .in_kdata_o(IN_KDATA_O)
  );

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_upper_zero;
    @(posedge MCLK_I) disable iff (SRST_I)
      RD_STB_I |=> (RD_DATA_O[RKPP_DATA_W-1:RKPP_UPPER_LSB] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half of read data not zero");

  property p_base_write;
    @(posedge MCLK_I) disable iff (SRST_I)
      (WR_STB_I && ADDR_I == RKPP_OFS_KBASE) |=>
        (KPROG_BASE_O[RKPP_KBASE_MSB:RKPP_KBASE_LSB] == $past(WR_DATA_I[RKPP_KBASE_MSB:RKPP_KBASE_LSB]))
        && (KPROG_PRESENT_O == ($past(WR_DATA_I[RKPP_KBASE_MSB:RKPP_KBASE_LSB]) != '0));
  endproperty
  a_base_write: assert property (p_base_write) else $error("base field did not take written value");

  property p_base_readback;
    @(posedge MCLK_I) disable iff (SRST_I)
      (RD_STB_I && ADDR_I == RKPP_OFS_KBASE) |=>
        (RD_DATA_O[RKPP_IMPL_MSB:0] == $past(KPROG_BASE_O)) && (RD_DATA_O[RKPP_KBASE_LSB-1:0] == '0);
  endproperty
  a_base_readback: assert property (p_base_readback) else $error("base readback wrong or low bits set");

  property p_low_zero;
    @(posedge MCLK_I) disable iff (SRST_I)
      WR_STB_I |=> (KPROG_BASE_O[RKPP_KBASE_LSB-1:0] == '0);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("base low bits not zero after write");

  property p_reset_clear;
    @(posedge MCLK_I)
      SRST_I |=> (KPROG_BASE_O == '0) && !KPROG_PRESENT_O && (KDATA_LEN_O == RKPP_DSIZE_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear the base");

  property p_ignore_other;
    @(posedge MCLK_I) disable iff (SRST_I)
      !(WR_STB_I && ADDR_I == RKPP_OFS_KBASE) |=> $stable(KPROG_BASE_O);
  endproperty
  a_ignore_other: assert property (p_ignore_other) else $error("base changed without a base write");

  property p_over_flag;
    @(posedge MCLK_I) disable iff (SRST_I)
      WR_STB_I ##1 !WR_STB_I |-> (LIMIT_ERR_O == (KPROG_BASE_O > data_ram_size_value));
  endproperty
  a_over_flag: assert property (p_over_flag) else $error("limit flag disagrees with base and size");

  property p_rd_one_cycle;
    @(posedge MCLK_I) disable iff (SRST_I)
      !RD_STB_I |=> (RD_DATA_O == RKPP_RD_IDLE);
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read data held beyond one cycle");

  property p_reset_rd;
    @(posedge MCLK_I)
      SRST_I |=> (RD_DATA_O == RKPP_RD_IDLE) && !LIMIT_ERR_O && !IN_KPROG_O && !IN_KDATA_O;
  endproperty
  a_reset_rd: assert property (p_reset_rd) else $error("reset left a status or read output set");

  property p_unmapped_read;
    @(posedge MCLK_I) disable iff (SRST_I)
      (RD_STB_I && ADDR_I != RKPP_OFS_KBASE && ADDR_I != RKPP_OFS_DSIZE && ADDR_I != RKPP_OFS_STAT)
        |=> (RD_DATA_O == RKPP_RD_IDLE);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned non-zero data");

  property p_present_match;
    @(posedge MCLK_I) disable iff (SRST_I)
      KPROG_PRESENT_O == (KPROG_BASE_O != '0);
  endproperty
  a_present_match: assert property (p_present_match) else $error("present flag disagrees with base");

  // with no program region the data length falls back to the size setting
  property p_kdata_len;
    @(posedge MCLK_I) disable iff (SRST_I)
      KDATA_LEN_O == (KPROG_PRESENT_O ? KPROG_BASE_O : data_ram_size_value);
  endproperty
  a_kdata_len: assert property (p_kdata_len) else $error("kernel data length wrong");

  property p_size_write;
    @(posedge MCLK_I) disable iff (SRST_I)
      (WR_STB_I && ADDR_I == RKPP_OFS_DSIZE) |=> (data_ram_size_value == $past(WR_DATA_I[RKPP_IMPL_MSB:0]));
  endproperty
  a_size_write: assert property (p_size_write) else $error("size setting did not take written value");

  property p_size_hold;
    @(posedge MCLK_I) disable iff (SRST_I)
      !(WR_STB_I && ADDR_I == RKPP_OFS_DSIZE) |=> $stable(data_ram_size_value);
  endproperty
  a_size_hold: assert property (p_size_hold) else $error("size setting changed without a size write");

  property p_size_readback;
    @(posedge MCLK_I) disable iff (SRST_I)
      (RD_STB_I && ADDR_I == RKPP_OFS_DSIZE) |=> (RD_DATA_O[RKPP_IMPL_MSB:0] == $past(data_ram_size_value));
  endproperty
  a_size_readback: assert property (p_size_readback) else $error("size readback wrong");

  // status is read-only, so a write there must reach neither setting
  property p_stat_write_ignored;
    @(posedge MCLK_I) disable iff (SRST_I)
      (WR_STB_I && ADDR_I == RKPP_OFS_STAT) |=> $stable(KPROG_BASE_O) && $stable(data_ram_size_value);
  endproperty
  a_stat_write_ignored: assert property (p_stat_write_ignored) else $error("status write changed a setting");

  property p_stat_readback;
    @(posedge MCLK_I) disable iff (SRST_I)
      (RD_STB_I && ADDR_I == RKPP_OFS_STAT) |=>
        (RD_DATA_O[RKPP_STAT_PRESENT] == $past(KPROG_PRESENT_O)) && (RD_DATA_O[RKPP_STAT_OVER] == $past(LIMIT_ERR_O));
  endproperty
  a_stat_readback: assert property (p_stat_readback) else $error("status readback wrong");

  property p_limit_hold;
    @(posedge MCLK_I) disable iff (SRST_I)
      !WR_STB_I |=> $stable(LIMIT_ERR_O);
  endproperty
  a_limit_hold: assert property (p_limit_hold) else $error("limit flag moved without a write");

  // a read must never disturb either setting
  property p_rd_side_effect;
    @(posedge MCLK_I) disable iff (SRST_I)
      RD_STB_I |=> $stable(KPROG_BASE_O) && $stable(data_ram_size_value);
  endproperty
  a_rd_side_effect: assert property (p_rd_side_effect) else $error("read changed a setting");

  //////////////////////////////////////////////////////////////////////////////
  // classifier checks

  // one cycle late: flags judge last cycle's offset against last cycle's settings
  property p_in_kprog;
    @(posedge MCLK_I) disable iff (SRST_I)
      1'b1 |=> (IN_KPROG_O == (($past(KPROG_BASE_O) != '0) && ($past(RAM_ADDR_I) >= $past(KPROG_BASE_O))
                && ($past(RAM_ADDR_I) < $past(data_ram_size_value))));
  endproperty
  a_in_kprog: assert property (p_in_kprog) else $error("program region flag wrong");

  property p_in_kdata;
    @(posedge MCLK_I) disable iff (SRST_I)
      1'b1 |=> (IN_KDATA_O == (($past(RAM_ADDR_I) < $past(data_ram_size_value)) && !IN_KPROG_O));
  endproperty
  a_in_kdata: assert property (p_in_kdata) else $error("data region flag wrong");

  property p_regions_apart;
    @(posedge MCLK_I) disable iff (SRST_I)
      !(IN_KPROG_O && IN_KDATA_O);
  endproperty
  a_regions_apart: assert property (p_regions_apart) else $error("offset flagged as program and data");

  c_set_region: cover property (@(posedge MCLK_I) disable iff (SRST_I)
    (WR_STB_I && ADDR_I == RKPP_OFS_KBASE && WR_DATA_I[RKPP_KBASE_MSB:RKPP_KBASE_LSB] != '0) ##1 KPROG_PRESENT_O);
  c_clear_region: cover property (@(posedge MCLK_I) disable iff (SRST_I)
    KPROG_PRESENT_O ##1 (WR_STB_I && ADDR_I == RKPP_OFS_KBASE) ##1 !KPROG_PRESENT_O);
  c_limit: cover property (@(posedge MCLK_I) disable iff (SRST_I) $rose(LIMIT_ERR_O));
  c_in_prog: cover property (@(posedge MCLK_I) disable iff (SRST_I) IN_KPROG_O);
  c_size_read: cover property (@(posedge MCLK_I) disable iff (SRST_I) RD_STB_I && ADDR_I == RKPP_OFS_DSIZE);

endmodule : rkpp_partition

`default_nettype wire

// file: test_rkpp_partition.sv
// self-checking testbench for the kernel program partition block
`timescale 1ns/10ps
`default_nettype none

module test_rkpp_partition;
  import rkpp_pkg::*;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [RKPP_ADDR_W-1:0] addr = '0;
  logic [RKPP_DATA_W-1:0] wdat = '0;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [RKPP_RAM_W-1:0] ram_addr = '0;
  logic [RKPP_DATA_W-1:0] rdat;
  logic [RKPP_RAM_W-1:0] kbase;
  logic [RKPP_RAM_W-1:0] klen;
  logic kpres;
  logic lerr;
  logic in_kp;
  logic in_kd;
  int fails = 0;
  int checks_done = 0;

  always #12.5 mclk = ~mclk;

  rkpp_partition dut_u (
    .MCLK_I(mclk),
    .SRST_I(srst),
    .ADDR_I(addr),
    .WR_DATA_I(wdat),
    .WR_STB_I(wstb),
    .RD_STB_I(rstb),
    .RD_DATA_O(rdat),
    .RAM_ADDR_I(ram_addr),
    .KPROG_BASE_O(kbase),
    .KDATA_LEN_O(klen),
    .KPROG_PRESENT_O(kpres),
    .LIMIT_ERR_O(lerr),
    .IN_KPROG_O(in_kp),
    .IN_KDATA_O(in_kd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wstb <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge mclk);
    wstb <= 1'b0;
    #1;
  endtask : wr

  // read data only stands one cycle, so it is sampled just after that edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rstb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rstb <= 1'b0;
    #1;
    chk("read data", rdat, exp);
  endtask : rd

  task automatic cls(input logic [15:0] a, input logic kp, input logic kd);
    @(posedge mclk);
    ram_addr <= a;
    @(posedge mclk);
    #1;
    chk("in program", {31'h0, in_kp}, {31'h0, kp});
    chk("in data", {31'h0, in_kd}, {31'h0, kd});
  endtask : cls

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rd(RKPP_OFS_KBASE, 32'h0000_0000);
    chk("present", {31'h0, kpres}, 32'h0000_0000);
    chk("data len", {16'h0, klen}, 32'h0000_0000);
    // size set first so every base written before the deliberate breach below stays within it
    wr(RKPP_OFS_DSIZE, 32'hFFFF_FC00);
    rd(RKPP_OFS_DSIZE, 32'h0000_FC00);
    chk("data len", {16'h0, klen}, 32'h0000_FC00);
    // all ones: only bits 15-10 may stick
    wr(RKPP_OFS_KBASE, 32'hFFFF_FFFF);
    chk("base out", {16'h0, kbase}, 32'h0000_FC00);
    rd(RKPP_OFS_KBASE, 32'h0000_FC00);
    wr(RKPP_OFS_KBASE, 32'hFFFF_03FF);
    rd(RKPP_OFS_KBASE, 32'h0000_0000);
    chk("present", {31'h0, kpres}, 32'h0000_0000);
    // walk one bit through the field
    for (int k = 10; k < 16; k++) begin
      wr(RKPP_OFS_KBASE, (32'h1 << k) | 32'h5A5A_0155);
      rd(RKPP_OFS_KBASE, 32'h1 << k);
    end
    // base comes down before the size shrinks below it
    wr(RKPP_OFS_KBASE, 32'h0000_0C00);
    wr(RKPP_OFS_DSIZE, 32'h0000_4000);
    chk("data len", {16'h0, klen}, 32'h0000_0C00);
    chk("present", {31'h0, kpres}, 32'h0000_0001);
    chk("limit", {31'h0, lerr}, 32'h0000_0000);
    cls(16'h0C00, 1'b1, 1'b0);
    cls(16'h0BFF, 1'b0, 1'b1);
    cls(16'h4000, 1'b0, 1'b0);
    // status is read-only
    wr(RKPP_OFS_STAT, 32'hFFFF_FFFF);
    chk("base out", {16'h0, kbase}, 32'h0000_0C00);
    rd(RKPP_OFS_STAT, 32'h0000_0001);
    // deliberate breach: hardware only flags an oversized base, it still takes it
    wr(RKPP_OFS_KBASE, 32'h0000_8000);
    chk("limit", {31'h0, lerr}, 32'h0000_0001);
    rd(RKPP_OFS_STAT, 32'h0000_0003);
    cls(16'h9000, 1'b0, 1'b0);
    rd(8'h10, 32'h0000_0000);
    // reset in mid-run gives all RAM back to data
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd(RKPP_OFS_KBASE, 32'h0000_0000);
    chk("base out", {16'h0, kbase}, 32'h0000_0000);
    chk("limit", {31'h0, lerr}, 32'h0000_0000);
    rd(RKPP_OFS_DSIZE, 32'h0000_0000);
    wr(RKPP_OFS_DSIZE, 32'h0000_4000);
    chk("data len", {16'h0, klen}, 32'h0000_4000);
    cls(16'h0100, 1'b0, 1'b1);
    cls(16'h3FFF, 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

endmodule : test_rkpp_partition

`default_nettype wire
